// ==== design/isp_pkg.sv ====
// Purpose: Shared constants and types for the inertial sensor serial port
// Assumes: 16-bit frames, 6-bit byte addresses, 16-bit output registers
// Notes:   Register offsets are the even (lower byte) addresses
package isp_pkg;

  localparam int FRAME_BITS  = 16;
  localparam int ADDR_W      = 6;
  localparam int NUM_CH      = 11;
  localparam int CH_W        = 4;
  localparam int FIFO_DEPTH  = 8;

  localparam logic [5:0] SUPPLY_VOLTAGE_OUT = 6'h02;
  localparam logic [5:0] RATE_X_OUT         = 6'h04;
  localparam logic [5:0] RATE_Y_OUT         = 6'h06;
  localparam logic [5:0] RATE_Z_OUT         = 6'h08;
  localparam logic [5:0] ACCEL_X_OUT        = 6'h0A;
  localparam logic [5:0] ACCEL_Y_OUT        = 6'h0C;
  localparam logic [5:0] ACCEL_Z_OUT        = 6'h0E;
  localparam logic [5:0] TEMP_X_OUT         = 6'h10;
  localparam logic [5:0] TEMP_Y_OUT         = 6'h12;
  localparam logic [5:0] TEMP_Z_OUT         = 6'h14;
  localparam logic [5:0] AUX_ANALOG_OUT     = 6'h16;
  localparam logic [5:0] OUT_FIRST          = SUPPLY_VOLTAGE_OUT;
  localparam logic [5:0] OUT_LAST           = AUX_ANALOG_OUT;

  // Field positions in an output word
  localparam int NEW_BIT     = 15;
  localparam int ERR_BIT     = 14;
  localparam int WIDE_MSB    = 13;
  localparam int NARROW_MSB  = 11;

  // Command word layout
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ZERO_BIT  = 14;
  localparam int CMD_ADDR_LSB  = 8;

  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // A new sample for one output register
  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [13:0]     data;
  } isp_sample_t;

  // A decoded write frame handed to the control register store
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } isp_wr_t;

endpackage

// ==== design/isp_fifo.sv ====
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full and empty come from a separate occupancy count
`timescale 1ns/1ps
module isp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,      // System clock
  input  wire logic             rst,       // Async reset, active high
  input  wire logic [WIDTH-1:0] in_data,   // Fill data
  input  wire logic             in_valid,  // Fill valid
  output logic                  in_ready,  // Not full
  output logic [WIDTH-1:0]      out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Drain accepts
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ==== design/isp_sync.sv ====
// Purpose: Two flip-flop synchroniser for the serial pins
// Assumes: Inputs asynchronous to mclk
// Notes:   Reset value chosen per bit so an idle bus reads as idle
`timescale 1ns/1ps
module isp_sync #(
  parameter int          W    = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk,  // System clock
  input  wire logic         rst,   // Async reset, active high
  input  wire logic [W-1:0] d,     // Asynchronous levels
  output logic [W-1:0]      q      // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== design/isp_port.sv ====
// Purpose: Serial slave port giving access to sensor output registers
// Assumes: Serial clock idles high, data out changes after falling edges,
//          host samples on rising edges; mclk well above serial clock rate
// Notes:   Samples arrive through an 8-word FIFO from the conversion side
// Functional notes
// - Chip select high: output off, inputs ignored
// - Frames are sixteen clocks, full duplex
// - Write changes only the addressed byte
// - Either byte address returns whole word
// - Last eight bits of read ignored
// - Read data returned in next frame
// - Sixteen-bit registers, two byte addresses each
// - Outputs keep updating regardless of reads
// - Bit 15 set on new sample
// - Reading clears the new sample bit
// - Bit 14 shows error or alarm
// - Twelve-bit outputs ignore bits 13, 12
// - Rates: 14-bit signed at 0x04-0x09
// - Accelerations: 14-bit signed at 0x0A-0x0F
// - Temperatures: 12-bit signed at 0x10-0x15
// - Supply: 12-bit unsigned at 0x02-0x03
// - Auxiliary input: 12-bit unsigned at 0x16
// - Rate coding 14-bit two's complement
// - MSB at select fall, then after falls
`timescale 1ns/1ps
module isp_port
  import isp_pkg::*;
(
  input  wire logic        mclk,          // System clock, 200 MHz
  input  wire logic        rst,           // Async reset, active high
  input  wire logic        sclk,          // Serial clock pin
  input  wire logic        cs_n,          // Chip select pin, active low
  input  wire logic        sdi,           // Serial data in pin
  output logic             sdo_o,         // Serial data out value
  output logic             sdo_oe,        // Serial data out enable
  input  wire isp_sample_t smp_data,      // New sample: channel and value
  input  wire logic        smp_valid,     // Sample valid
  output logic             smp_ready,     // Sample FIFO has room
  input  wire logic        error_alarm,   // System error or alarm level
  output isp_wr_t          wr_data,       // Accepted control byte write
  output logic             wr_valid       // One-cycle write strobe
);
  localparam int SW = $bits(isp_sample_t);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} st_t;

  logic [2:0]      pins;
  logic            sclk_s;
  logic            cs_n_s;
  logic            sdi_s;
  logic            sclk_q;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            frame_start;
  st_t             st_q;
  logic [4:0]      bit_q;
  logic [15:0]     rx_q;
  logic [15:0]     rx_word;
  logic [15:0]     tx_q;
  logic [15:0]     next_tx_q;
  logic [15:0]     obs_q [NUM_CH];
  logic            frame_end;
  logic            is_read;
  logic            is_write;
  logic [CH_W-1:0] rd_ch;
  logic            rd_hit;
  isp_sample_t     f_data;
  logic            f_valid;
  logic            f_ready;

  // Map a byte address to an output channel; both byte addresses share one
  function automatic logic [CH_W-1:0] ch_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off   = a - OUT_FIRST;
    ch_of = off[CH_W:1];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a >= OUT_FIRST) && (a <= (OUT_LAST + 6'h01));
  endfunction

  // Build the stored word from a sample, by channel width
  function automatic logic [15:0] pack_word(input logic [CH_W-1:0] c, input logic [13:0] v);
    logic wide;
    wide = (c >= ch_of(RATE_X_OUT)) && (c <= ch_of(ACCEL_Z_OUT));
    if (wide) begin
      pack_word = {2'b10, v};
    end else begin
      pack_word = {2'b10, 2'b00, v[NARROW_MSB:0]};
    end
  endfunction

  isp_sync #(
    .W    (3),
    .INIT (3'b110)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({sclk, cs_n, sdi}),
    .q    (pins)
  );

  assign sclk_s = pins[2];
  assign cs_n_s = pins[1];
  assign sdi_s  = pins[0];

  isp_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (smp_data),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // Edge detection on the synchronised clock, only while selected
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  assign sclk_rise   = !cs_n_s && sclk_s && !sclk_q;
  assign sclk_fall   = !cs_n_s && !sclk_s && sclk_q;
  assign frame_start = (st_q == ST_IDLE) && !cs_n_s;
  assign rx_word     = {rx_q[14:0], sdi_s};
  assign frame_end   = sclk_rise && (bit_q == 5'(FRAME_BITS - 1));

  // Frame sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q  <= ST_IDLE;
      bit_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          bit_q <= '0;
          if (!cs_n_s) begin
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_n_s) begin
            st_q <= ST_IDLE;
          end else if (frame_end) begin
            st_q <= ST_DONE;
          end else if (sclk_rise) begin
            bit_q <= bit_q + 5'd1;
          end
        end
        ST_DONE: begin
          if (cs_n_s) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive shift register, MSB first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_q <= WORD_ZERO;
    end else if (st_q == ST_SHIFT && sclk_rise) begin
      rx_q <= rx_word;
    end
  end

  assign is_write = frame_end && rx_word[CMD_WRITE_BIT] && !rx_word[CMD_ZERO_BIT];
  assign is_read  = frame_end && !rx_word[CMD_WRITE_BIT] && !rx_word[CMD_ZERO_BIT];
  assign rd_ch    = ch_of(rx_word[CMD_ADDR_LSB +: ADDR_W]);
  assign rd_hit   = is_read && mapped(rx_word[CMD_ADDR_LSB +: ADDR_W]);

  // Control byte writes go out as one strobe; output registers are read only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else begin
      wr_valid <= is_write && !mapped(rx_word[CMD_ADDR_LSB +: ADDR_W]);
      if (is_write) begin
        wr_data <= '{addr: rx_word[CMD_ADDR_LSB +: ADDR_W], data: rx_word[7:0]};
      end
    end
  end

  // Latch read word at end of frame, shifted out in the next one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      next_tx_q <= WORD_ZERO;
    end else if (is_read) begin
      next_tx_q <= rd_hit ? obs_q[rd_ch] : WORD_ZERO;
    end
  end

  // Transmit shift register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_q <= WORD_ZERO;
    end else if (frame_start) begin
      tx_q <= next_tx_q;
    end else if (st_q == ST_SHIFT && sclk_fall && bit_q != '0) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Output words: samples always load, reads clear the new flag
  assign f_ready = 1'b1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        obs_q[i] <= WORD_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (f_valid && f_data.ch == CH_W'(i)) begin
          obs_q[i] <= pack_word(f_data.ch, f_data.data);
        end else if (rd_hit && rd_ch == CH_W'(i)) begin
          obs_q[i][NEW_BIT] <= 1'b0;
        end
        obs_q[i][ERR_BIT] <= error_alarm;
      end
    end
  end

  assign sdo_oe = !cs_n_s && (st_q != ST_IDLE);
  assign sdo_o  = sdo_oe ? tx_q[15] : 1'b0;
endmodule

// ==== testbench/isp_port_assertions.sv ====
// Purpose: Port-level checks for the serial port
// Assumes: Bound to isp_port; frames end well before select rises
// Notes:   Disabled while rst is high
`timescale 1ns/1ps
module isp_port_assertions
  import isp_pkg::*;
(
  input wire logic    mclk,     // System clock
  input wire logic    rst,      // Async reset
  input wire logic    sclk,     // Serial clock pin
  input wire logic    cs_n,     // Chip select pin
  input wire logic    sdo_o,    // Data out value
  input wire logic    sdo_oe,   // Data out enable
  input wire isp_wr_t wr_data,  // Write payload
  input wire logic    wr_valid  // Write strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_select;
    $fell(cs_n) ##1 !cs_n;
  endsequence
  a_oe_on_select: assert property (s_select |-> ##[0:4] sdo_oe)
    else $error("data out not driven after select");
  a_oe_off_idle: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_out_quiet: assert property (!sdo_oe |-> !sdo_o)
    else $error("data value while not driving");
  a_oe_hold: assert property (sdo_oe && !cs_n |=> sdo_oe)
    else $error("drive dropped inside frame");
  a_shift_low: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk)
    else $error("data out changed while clock high");
  a_wr_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write strobe longer than one cycle");
  a_wr_ctrl_only: assert property (wr_valid |-> wr_data.addr > 6'h17)
    else $error("write accepted at output address");
  a_wr_idle: assert property (cs_n [*8] |-> !wr_valid)
    else $error("write strobe while deselected");
endmodule
bind isp_port isp_port_assertions u_chk (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdo_o(sdo_o),
  .sdo_oe(sdo_oe), .wr_data(wr_data), .wr_valid(wr_valid));

// ==== testbench/isp_host.sv ====
// Purpose: Host master model driving the serial link
// Assumes: Clock idles high, host samples data out on rising edges
// Notes:   Frame gap shortened for simulation
`timescale 1ns/1ps
module isp_host #(
  parameter int HALF = 16,  // mclk cycles per serial half period
  parameter int GAP  = 24   // Idle cycles between frames
) (
  input  wire logic   mclk,  // System clock
  output logic        sclk,  // Serial clock
  output logic        cs_n,  // Chip select, active low
  output logic        sdi,   // Data to device
  input  wire logic   sdo,   // Data from device
  output logic [15:0] rx,    // Word received
  output logic        done   // One-cycle frame end
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi  = 1'b0;
    rx   = 16'h0000;
    done = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int nb);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
    for (int i = 15; i > 15 - nb; i--) begin
      sclk <= 1'b0;
      sdi  <= tx[i];
      repeat (HALF) @(posedge mclk);
      sclk  <= 1'b1;
      rx[i] <= sdo;
      repeat (HALF) @(posedge mclk);
    end
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    repeat (GAP) @(posedge mclk);
  endtask
  // Activity while deselected
  task automatic junk();
    repeat (6) begin
      sclk <= ~sclk;
      sdi  <= ~sdi;
      repeat (HALF) @(posedge mclk);
    end
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the serial port
// Assumes: Host model drives the link, bench drives samples
// Notes:   Reads answer one frame late, so expectations are pipelined
`timescale 1ns/1ps
module tb_top
  import isp_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, error_alarm = 1'b0, smp_valid = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_o, sdo_oe, smp_ready, wr_valid, h_done;
  isp_sample_t smp_data = '0;
  isp_wr_t     wr_data, wq[$];
  logic [15:0] h_rx;
  logic [13:0] val [NUM_CH];
  logic        nflag [NUM_CH];
  logic [16:0] pend = '0, eq[$];
  logic [31:0] seed = 32'h0001180C;
  int          n_mismatch = 0, n_tests = 0;
  always #2.5 mclk = ~mclk;
  assign sdo = sdo_oe ? sdo_o : 1'bz;
  isp_port dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready), .error_alarm(error_alarm),
    .wr_data(wr_data), .wr_valid(wr_valid));
  isp_host u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .rx(h_rx), .done(h_done));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] word_of(input logic [5:0] a);
    int c;
    c = int'(a >> 1) - 1;
    if (a < OUT_FIRST || a > OUT_LAST + 6'h01) return WORD_ZERO;
    if (c == 0 || c >= 7) return {nflag[c], error_alarm, 2'b00, val[c][11:0]};
    return {nflag[c], error_alarm, val[c]};
  endfunction
  task automatic frame(input logic [15:0] tx, input int nb);
    eq.push_back(pend);
    pend = '0;
    if (nb == 16 && tx[15:14] == 2'b10 && tx[13:8] > 6'h17) wq.push_back({tx[13:8], tx[7:0]});
    u_host.xfer(tx, nb);
    if (nb == 16 && tx[15:14] == 2'b00) begin
      pend = {1'b1, word_of(tx[13:8])};
      if (tx[13:8] >= OUT_FIRST && tx[13:8] <= OUT_LAST + 6'h01) nflag[(tx[13:8] >> 1) - 1] = 1'b0;
    end
  endtask
  task automatic sample(input int c, input logic [13:0] d);
    smp_data <= {4'(c), d};
    smp_valid <= 1'b1;
    @(posedge mclk);
    val[c] = d;
    nflag[c] = 1'b1;
  endtask
  always @(posedge mclk) begin
    if (h_done) begin
      if (eq[0][16]) chk(18'(h_rx), 18'(eq[0][15:0]));
      void'(eq.pop_front());
    end
    if (wr_valid) chk(18'(wr_data), wq.size() ? 18'(wq.pop_front()) : 18'h3FFFF);
    if (smp_valid) chk(18'(smp_ready), 18'h1);
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    for (int c = 0; c < NUM_CH; c++) begin
      val[c] = '0;
      nflag[c] = 1'b0;
    end
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 26; a++) frame({2'b00, 6'(a), 8'(rnd())}, 16);
    for (int c = 0; c < NUM_CH; c++) sample(c, 14'(rnd()));
    sample(1, 14'h3FFF);
    sample(2, 14'h1110);
    smp_valid <= 1'b0;
    error_alarm <= 1'b1;
    repeat (4) @(posedge mclk);
    // Lower then upper byte of each word: new flag seen once, then cleared
    for (int c = 0; c < 2 * NUM_CH; c++) begin
      frame({2'b00, 6'(c + 2), 8'(rnd())}, 16);
      if (c == 9) error_alarm <= 1'b0;
    end
    frame(16'hBE5A, 16);
    frame({2'b10, 6'h3F, 8'(rnd())}, 16);
    frame({2'b10, 6'h04, 8'hFF}, 16);
    frame({2'b01, 6'h3E, 8'h11}, 16);
    frame({2'b11, 6'h3E, 8'h22}, 16);
    frame({2'b10, 6'h30, 8'hA5}, 10);
    u_host.junk();
    frame({2'b00, 6'h05, 8'(rnd())}, 16);
    frame(16'h0000, 16);
    chk(18'(wq.size()), 18'h0);
    // Burst of samples through the sample FIFO; the last one must stand in the word
    for (int i = 0; i < 10; i++) sample(4, 14'(rnd()));
    smp_valid <= 1'b0;
    repeat (4) @(posedge mclk);
    frame({2'b00, ACCEL_X_OUT, 8'(rnd())}, 16);
    frame(16'h0000, 16);
    chk(18'(smp_ready), 18'h1);
    chk(18'(eq.size()), 18'h0);
    chk(18'(sdo_oe), 18'h0);
    summarize();
  end
endmodule
